// ===== osc_ctrl.sv
// clock source select and divider control: registers, unlock, switch sequencer
// assumes oscillator ready, pll lock and monitor fail come from analog side, synchronous
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [15:0] readData,
  input wire logic [2:0] initial_source_cfg,
  input wire logic [1:0] primary_submode_cfg,
  input wire logic [1:0] switch_monitor_cfg,
  input wire logic newSourceReady,
  input wire logic newSourceTick,
  input wire logic pllLocked,
  input wire logic clockFailDetect,
  input wire logic interruptEvent,
  output logic [2:0] activeSource,
  output logic [1:0] primarySubmode,
  output logic secondaryOscOn,
  output logic pinSelectWriteAllowed,
  output logic [7:0] dozeDivisor,
  output logic [8:0] fastRcDivisor,
  output logic [3:0] pllPostDivisor,
  output logic [5:0] pllPreDivisor,
  output logic [9:0] pllMultiplier,
  output logic [5:0] fastRcTrim,
  output logic instrClockDivide2
);
  //////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [2:0] curSrc;             // source in use
    logic [2:0] nextSrc;            // switch target
    logic [1:0] submode;            // primary submode captured after reset
    logic switchLock;               // blocks switching, only with monitor off
    logic pinLock;                  // blocks pin select writes
    logic clockFail;                // sticky fail flag
    logic secEn;                    // secondary oscillator enable
    logic switchReq;                // switch in progress
    logic recover_on_interrupt;                      // recover on interrupt
    logic [2:0] doze;               // doze ratio code
    logic dozeEn;                   // doze enable
    logic [2:0] frcPost;            // fast RC postscale code
    logic [1:0] pllPost;            // pll postscale code
    logic [4:0] pllPre;             // pll prescale code
    logic [8:0] pllFb;              // pll feedback code
    logic [5:0] trim;               // fast RC trim code
    logic [1:0] unlockStage;        // 0 none, 1 first key, 2 unlocked
    logic [3:0] waitCount;          // new source cycles seen
    osc_ctrl_pkg::switch_state_t sw; // sequencer state
    logic cfgLoaded;                // config captured after reset
    logic [15:0] rdata;             // read data register
  } state_t;

  state_t cur;
  state_t next_cur;

  //////////////////////////////////////////////////////////////////////
  // functions
  // power of two as a divisor value
  function automatic logic [8:0] pow2(input logic [3:0] n);
    pow2 = 9'h001 << n;
  endfunction

  // switching allowed at all by configuration
  logic switchEnabled;
  assign switchEnabled = ~switch_monitor_cfg[1];
  // lock bit only bites with switching on and monitor off
  logic switchBlocked;
  assign switchBlocked = cur.switchLock &&
                         (switch_monitor_cfg == osc_ctrl_pkg::SWITCH_NO_MONITOR);

  // write decode
  logic unlocked;
  assign unlocked = cur.unlockStage == 2'h2;

  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_cur = cur;
    next_cur.rdata = 16'h0000;
    // capture configuration on the first cycle after reset
    if (!cur.cfgLoaded) begin
      next_cur.cfgLoaded = 1'b1;
      next_cur.curSrc = initial_source_cfg;
      next_cur.nextSrc = initial_source_cfg;
      next_cur.submode = primary_submode_cfg;
    end
    // unlock sequencer: any write consumes the unlock
    if (writeStrobe) begin
      if (addr == osc_ctrl_pkg::ADDR_UNLOCK_KEY &&
          writeData == osc_ctrl_pkg::UNLOCK_KEY_FIRST) begin
        next_cur.unlockStage = 2'h1;
      end else if (addr == osc_ctrl_pkg::ADDR_UNLOCK_KEY && cur.unlockStage == 2'h1 &&
                   writeData == osc_ctrl_pkg::UNLOCK_KEY_SECOND) begin
        next_cur.unlockStage = 2'h2;
      end else begin
        next_cur.unlockStage = 2'h0;
      end
    end
    // register writes
    if (writeStrobe && cur.cfgLoaded) begin
      unique case (addr)
        osc_ctrl_pkg::ADDR_OSC_CONTROL: begin
          if (unlocked) begin
            next_cur.nextSrc = writeData[osc_ctrl_pkg::NEXT_SRC_LSB +: 3];
            next_cur.switchLock = writeData[osc_ctrl_pkg::SWITCH_LOCK_POS];
            next_cur.pinLock = writeData[osc_ctrl_pkg::PIN_LOCK_POS];
            next_cur.secEn = writeData[osc_ctrl_pkg::SEC_OSC_EN_POS];
            // writing zero clears the fail flag, writing one keeps it
            if (!writeData[osc_ctrl_pkg::CLOCK_FAIL_POS]) begin
              next_cur.clockFail = 1'b0;
            end
            // request only when switching allowed and idle
            if (writeData[osc_ctrl_pkg::SWITCH_REQ_POS] && switchEnabled && !switchBlocked &&
                cur.sw == osc_ctrl_pkg::SW_IDLE) begin
              next_cur.switchReq = 1'b1;
            end
          end
        end
        osc_ctrl_pkg::ADDR_CLOCK_DIVISOR: begin
          next_cur.recover_on_interrupt = writeData[osc_ctrl_pkg::ROI_POS];
          next_cur.doze = writeData[osc_ctrl_pkg::DOZE_LSB +: 3];
          next_cur.dozeEn = writeData[osc_ctrl_pkg::DOZE_EN_POS];
          next_cur.frcPost = writeData[osc_ctrl_pkg::FRC_POST_LSB +: 3];
          // reserved postscale code is refused
          if (writeData[osc_ctrl_pkg::PLL_POST_LSB +: 2] != osc_ctrl_pkg::PLL_POST_RESERVED) begin
            next_cur.pllPost = writeData[osc_ctrl_pkg::PLL_POST_LSB +: 2];
          end
          next_cur.pllPre = writeData[osc_ctrl_pkg::PLL_PRE_LSB +: 5];
        end
        osc_ctrl_pkg::ADDR_PLL_FEEDBACK: begin
          next_cur.pllFb = writeData[8:0];
        end
        osc_ctrl_pkg::ADDR_FAST_RC_TUNING: begin
          next_cur.trim = writeData[5:0];
        end
        default: begin
          // unmapped and key addresses store nothing here
        end
      endcase
    end
    // recover on interrupt overrides a same-cycle write
    if (interruptEvent && cur.recover_on_interrupt) begin
      next_cur.dozeEn = 1'b0;
    end
    // switch sequencer
    unique case (cur.sw)
      osc_ctrl_pkg::SW_IDLE: begin
        if (cur.switchReq) begin
          if (cur.nextSrc == cur.curSrc) begin
            next_cur.switchReq = 1'b0;
          end else begin
            next_cur.clockFail = 1'b0;
            next_cur.waitCount = 4'h0;
            next_cur.sw = osc_ctrl_pkg::SW_WAIT_READY;
          end
        end
      end
      osc_ctrl_pkg::SW_WAIT_READY: begin
        if (newSourceReady) begin
          next_cur.sw = osc_ctrl_pkg::SW_COUNT;
        end
      end
      osc_ctrl_pkg::SW_COUNT: begin
        if (newSourceTick) begin
          next_cur.waitCount = cur.waitCount + 4'h1;
        end
        if (cur.waitCount == osc_ctrl_pkg::SWITCH_WAIT_CYCLES) begin
          next_cur.curSrc = cur.nextSrc;
          next_cur.switchReq = 1'b0;
          next_cur.sw = osc_ctrl_pkg::SW_IDLE;
        end
      end
      default: begin
        next_cur.sw = osc_ctrl_pkg::SW_IDLE;
      end
    endcase
    // switching off: request held low, current stays at config
    if (!switchEnabled) begin
      next_cur.switchReq = 1'b0;
      next_cur.sw = osc_ctrl_pkg::SW_IDLE;
      if (cur.cfgLoaded) begin
        next_cur.curSrc = initial_source_cfg;
      end
    end
    // monitor failure sets the flag; set wins over clear
    if (clockFailDetect && switchEnabled) begin
      next_cur.clockFail = 1'b1;
    end
    // read data, one cycle later
    if (readStrobe) begin
      unique case (addr)
        osc_ctrl_pkg::ADDR_OSC_CONTROL: begin
          next_cur.rdata[osc_ctrl_pkg::CUR_SRC_LSB +: 3] = cur.curSrc;
          next_cur.rdata[osc_ctrl_pkg::NEXT_SRC_LSB +: 3] = cur.nextSrc;
          next_cur.rdata[osc_ctrl_pkg::SWITCH_LOCK_POS] = cur.switchLock;
          next_cur.rdata[osc_ctrl_pkg::PIN_LOCK_POS] = cur.pinLock;
          next_cur.rdata[osc_ctrl_pkg::PLL_LOCK_POS] = pllLocked;
          next_cur.rdata[osc_ctrl_pkg::CLOCK_FAIL_POS] = cur.clockFail;
          next_cur.rdata[osc_ctrl_pkg::SEC_OSC_EN_POS] = cur.secEn;
          next_cur.rdata[osc_ctrl_pkg::SWITCH_REQ_POS] = cur.switchReq;
        end
        osc_ctrl_pkg::ADDR_CLOCK_DIVISOR: begin
          next_cur.rdata[osc_ctrl_pkg::ROI_POS] = cur.recover_on_interrupt;
          next_cur.rdata[osc_ctrl_pkg::DOZE_LSB +: 3] = cur.doze;
          next_cur.rdata[osc_ctrl_pkg::DOZE_EN_POS] = cur.dozeEn;
          next_cur.rdata[osc_ctrl_pkg::FRC_POST_LSB +: 3] = cur.frcPost;
          next_cur.rdata[osc_ctrl_pkg::PLL_POST_LSB +: 2] = cur.pllPost;
          next_cur.rdata[osc_ctrl_pkg::PLL_PRE_LSB +: 5] = cur.pllPre;
        end
        osc_ctrl_pkg::ADDR_PLL_FEEDBACK: begin
          next_cur.rdata[8:0] = cur.pllFb;
        end
        osc_ctrl_pkg::ADDR_FAST_RC_TUNING: begin
          next_cur.rdata[5:0] = cur.trim;
        end
        default: begin
          // unmapped reads return zero
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // reset values of the whole state; config fields are captured one cycle later
  localparam state_t RESET_STATE = '{
    curSrc: osc_ctrl_pkg::SRC_FAST_RC_DIV_N,
    nextSrc: osc_ctrl_pkg::SRC_FAST_RC_DIV_N,
    submode: 2'h3,
    switchLock: 1'b0,
    pinLock: 1'b0,
    clockFail: 1'b0,
    secEn: 1'b0,
    switchReq: 1'b0,
    recover_on_interrupt: 1'b0,
    doze: osc_ctrl_pkg::DOZE_RESET,
    dozeEn: 1'b0,
    frcPost: osc_ctrl_pkg::FRC_POST_RESET,
    pllPost: osc_ctrl_pkg::PLL_POST_RESET,
    pllPre: osc_ctrl_pkg::PLL_PRE_RESET,
    pllFb: osc_ctrl_pkg::PLL_FB_RESET,
    trim: osc_ctrl_pkg::TRIM_RESET,
    unlockStage: 2'h0,
    waitCount: 4'h0,
    sw: osc_ctrl_pkg::SW_IDLE,
    cfgLoaded: 1'b0,
    rdata: 16'h0000
  };

  // registers, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur <= RESET_STATE;
    end else begin
      cur <= next_cur;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign readData = cur.rdata;
  assign activeSource = cur.curSrc;
  assign primarySubmode = cur.submode;
  assign secondaryOscOn = cur.secEn;
  assign pinSelectWriteAllowed = ~cur.pinLock;
  // doze ratio, one when doze disabled
  logic [8:0] dozePow; // two to the doze code, top bit never set
  assign dozePow = pow2({1'b0, cur.doze});
  assign dozeDivisor = cur.dozeEn ? dozePow[7:0] : 8'h01;
  // fast RC postscale, code seven divides by 256
  assign fastRcDivisor = (cur.frcPost == 3'h7) ? 9'h100 : pow2({1'b0, cur.frcPost});
  // pll postscale: two, four, eight
  assign pllPostDivisor = (cur.pllPost == 2'h3) ? 4'h8 :
                          (cur.pllPost == 2'h1) ? 4'h4 : 4'h2;
  assign pllPreDivisor = {1'b0, cur.pllPre} + 6'h02;
  assign pllMultiplier = {1'b0, cur.pllFb} + 10'h002;
  assign fastRcTrim = cur.trim;
  assign instrClockDivide2 = 1'b1;
endmodule
`default_nettype wire

// ===== osc_ctrl_asserts.sv
// checker for the oscillator select and divider control block
// sees only the top module's ports; bound in at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic writeStrobe,
  input wire logic [2:0] initial_source_cfg,
  input wire logic [1:0] primary_submode_cfg,
  input wire logic [1:0] switch_monitor_cfg,
  input wire logic newSourceReady,
  input wire logic [2:0] activeSource,
  input wire logic [1:0] primarySubmode,
  input wire logic secondaryOscOn,
  input wire logic pinSelectWriteAllowed,
  input wire logic [7:0] dozeDivisor,
  input wire logic [8:0] fastRcDivisor,
  input wire logic [3:0] pllPostDivisor,
  input wire logic [9:0] pllMultiplier,
  input wire logic instrClockDivide2
);
  // one clock domain, reset disables every check
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // submode follows the config, never the software
  property p_submode; !$past(rst) |-> primarySubmode == $past(primary_submode_cfg); endproperty
  a_submode: assert property (p_submode) else $error("submode differs from config");
  // switching off: current source tracks the config
  property p_fixed_src; switch_monitor_cfg[1] && $past(switch_monitor_cfg[1]) && !$past(rst)
    |-> activeSource == $past(initial_source_cfg); endproperty
  a_fixed_src: assert property (p_fixed_src) else $error("source not from config");
  property p_instr; instrClockDivide2 == 1'b1; endproperty
  a_instr: assert property (p_instr) else $error("instruction divide flag low");
  // doze ratio is always a power of two
  property p_doze; $onehot(dozeDivisor); endproperty
  a_doze: assert property (p_doze) else $error("doze divisor not a power of two");
  // no divide by 128 code on the fast rc postscaler
  property p_frc; $onehot(fastRcDivisor) && fastRcDivisor != 9'h080; endproperty
  a_frc: assert property (p_frc) else $error("bad fast rc divisor");
  property p_post; pllPostDivisor inside {4'h2, 4'h4, 4'h8}; endproperty
  a_post: assert property (p_post) else $error("bad pll post divisor");
  property p_mult; pllMultiplier >= 10'h002 && pllMultiplier <= 10'h201; endproperty
  a_mult: assert property (p_mult) else $error("pll multiplier out of range");
  // control bits move only after a control register write
  property p_ctl; !$stable({pinSelectWriteAllowed, secondaryOscOn}) && !$past(rst)
    |-> $past(writeStrobe) && $past(addr) == 4'h0; endproperty
  a_ctl: assert property (p_ctl) else $error("control bit moved without write");
  // a real switch needs a ready new source
  property p_switch; !$stable(activeSource) && !$past(rst) && !$past(rst, 2)
    && !switch_monitor_cfg[1] |-> $past(newSourceReady); endproperty
  a_switch: assert property (p_switch) else $error("switch without ready source");
endmodule
bind osc_ctrl osc_ctrl_asserts i_osc_ctrl_asserts (.clk_sys(clk_sys), .rst(rst), .addr(addr),
  .writeStrobe(writeStrobe), .initial_source_cfg(initial_source_cfg),
  .primary_submode_cfg(primary_submode_cfg), .switch_monitor_cfg(switch_monitor_cfg),
  .newSourceReady(newSourceReady), .activeSource(activeSource), .primarySubmode(primarySubmode),
  .secondaryOscOn(secondaryOscOn), .pinSelectWriteAllowed(pinSelectWriteAllowed),
  .dozeDivisor(dozeDivisor), .fastRcDivisor(fastRcDivisor), .pllPostDivisor(pllPostDivisor),
  .pllMultiplier(pllMultiplier), .instrClockDivide2(instrClockDivide2));
`default_nettype wire

// ===== osc_ctrl_pkg.sv
// package of constants for the oscillator select and divider control block
// assumes a 16-bit register port with byte strobes folded into word writes
//
// Function
// - initial source config picks power-on clock
// - primary submode config picks crystal or external
// - unprogrammed config starts fast RC divide-by-N
// - current source field read-only at 14:12
// - next source field writable, loaded from config
// - switch lock bit blocks switching when set, only with switching on and monitor off
// - pin select lock refuses pin select writes
// - pll lock bit reflects lock or timer
// - clock fail flag set by monitor, software clears
// - secondary enable bit turns secondary oscillator on
// - switch request bit starts switch, clears when done
// - recover on interrupt clears doze enable
// - doze field divides by two to field
// - doze enable off forces ratio one
// - fast RC postscaler divides per code
// - pll postscaler divides two, four, eight
// - pll prescaler divides by field plus two
// - pll feedback multiplies by field plus two
// - trim field shifts fast RC in steps
// - switching never changes primary submode
// - switching enabled only when config bit zero
// - switching disabled: next field ignored; here it is still written and reads back
// - switching disabled: request bit held zero
// - instruction clock is oscillator divided by two
// - request to same source aborts as redundant
// - valid switch clears flags, waits ten cycles
package osc_ctrl_pkg;
  // register indices on the port, one 16-bit register each
  localparam logic [3:0] ADDR_OSC_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CLOCK_DIVISOR = 4'h1;
  localparam logic [3:0] ADDR_PLL_FEEDBACK = 4'h2;
  localparam logic [3:0] ADDR_FAST_RC_TUNING = 4'h3;
  localparam logic [3:0] ADDR_UNLOCK_KEY = 4'h4;
  // unlock key pair, written in order to the key register
  localparam logic [15:0] UNLOCK_KEY_FIRST = 16'h0055;
  localparam logic [15:0] UNLOCK_KEY_SECOND = 16'h00aa;
  // oscillator control field positions
  localparam int CUR_SRC_LSB = 12;
  localparam int NEXT_SRC_LSB = 8;
  localparam int SWITCH_LOCK_POS = 7;
  localparam int PIN_LOCK_POS = 6;
  localparam int PLL_LOCK_POS = 5;
  localparam int CLOCK_FAIL_POS = 3;
  localparam int SEC_OSC_EN_POS = 1;
  localparam int SWITCH_REQ_POS = 0;
  // clock divisor field positions
  localparam int ROI_POS = 15;
  localparam int DOZE_LSB = 12;
  localparam int DOZE_EN_POS = 11;
  localparam int FRC_POST_LSB = 8;
  localparam int PLL_POST_LSB = 6;
  localparam int PLL_PRE_LSB = 0;
  // reset values
  localparam logic [2:0] DOZE_RESET = 3'h3;
  localparam logic [2:0] FRC_POST_RESET = 3'h0;
  localparam logic [1:0] PLL_POST_RESET = 2'h1;
  localparam logic [4:0] PLL_PRE_RESET = 5'h00;
  localparam logic [8:0] PLL_FB_RESET = 9'h030;
  localparam logic [5:0] TRIM_RESET = 6'h00;
  // switch/monitor config value that enables switching without the monitor
  localparam logic [1:0] SWITCH_NO_MONITOR = 2'h1;
  // new source cycles to wait before the switch
  localparam logic [3:0] SWITCH_WAIT_CYCLES = 4'ha;
  // pll post code that is reserved
  localparam logic [1:0] PLL_POST_RESERVED = 2'h2;
  // clock source encodings
  typedef enum logic [2:0] {
    SRC_FAST_RC = 3'b000,
    SRC_FAST_RC_PLL = 3'b001,
    SRC_PRIMARY = 3'b010,
    SRC_PRIMARY_PLL = 3'b011,
    SRC_SECONDARY = 3'b100,
    SRC_LOW_POWER_RC = 3'b101,
    SRC_FAST_RC_DIV16 = 3'b110,
    SRC_FAST_RC_DIV_N = 3'b111
  } source_t;
  // switch sequencer states
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_WAIT_READY = 2'b01,
    SW_COUNT = 2'b10
  } switch_state_t;
endpackage

// ===== osc_ctrl_tb_top.sv
// self-checking bench for the oscillator select and divider control block
// assumes the 16-bit register port and unlock keys of the package
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] writeData = 16'h0000;
  logic writeStrobe = 1'b0, readStrobe = 1'b0;
  logic [2:0] srcCfg = 3'h7;
  logic [1:0] subCfg = 2'h3, smCfg = 2'h3;
  logic newSourceReady = 1'b0, newSourceTick = 1'b0, pllLocked = 1'b0;
  logic clockFailDetect = 1'b0, interruptEvent = 1'b0;
  logic [15:0] readData;
  logic [2:0] activeSource;
  logic [1:0] primarySubmode;
  logic secondaryOscOn, pinSelectWriteAllowed, instrClockDivide2;
  logic [7:0] dozeDivisor;
  logic [8:0] fastRcDivisor;
  logic [3:0] pllPostDivisor;
  logic [5:0] pllPreDivisor, fastRcTrim;
  logic [9:0] pllMultiplier;
  int fails = 0, compares = 0, cycles = 0;
  osc_ctrl i_osc_ctrl (.clk_sys(clk_sys), .rst(rst), .addr(addr), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
    .initial_source_cfg(srcCfg), .primary_submode_cfg(subCfg), .switch_monitor_cfg(smCfg),
    .newSourceReady(newSourceReady), .newSourceTick(newSourceTick), .pllLocked(pllLocked),
    .clockFailDetect(clockFailDetect), .interruptEvent(interruptEvent),
    .activeSource(activeSource), .primarySubmode(primarySubmode), .secondaryOscOn(secondaryOscOn),
    .pinSelectWriteAllowed(pinSelectWriteAllowed), .dozeDivisor(dozeDivisor),
    .fastRcDivisor(fastRcDivisor), .pllPostDivisor(pllPostDivisor), .pllPreDivisor(pllPreDivisor),
    .pllMultiplier(pllMultiplier), .fastRcTrim(fastRcTrim), .instrClockDivide2(instrClockDivide2));
  ////////////////////////////////////////////////////////////////////////////////
  // 100 ns clock and hang guard
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      complete_run;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // bus and helper tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    readStrobe <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    addr <= a;
    readStrobe <= 1'b1;
    writeStrobe <= 1'b0;
    @(posedge clk_sys);
    readStrobe <= 1'b0;
    @(negedge clk_sys);
    check(readData, exp);
  endtask
  task automatic unlock_wr(input logic [15:0] d);
    wr(osc_ctrl_pkg::ADDR_UNLOCK_KEY, osc_ctrl_pkg::UNLOCK_KEY_FIRST);
    wr(osc_ctrl_pkg::ADDR_UNLOCK_KEY, osc_ctrl_pkg::UNLOCK_KEY_SECOND);
    wr(osc_ctrl_pkg::ADDR_OSC_CONTROL, d);
  endtask
  // drop strobes, interrupt and fail pulses (not the new source tick), wait, end mid-cycle for checks
  task automatic idle(input int n);
    @(posedge clk_sys);
    writeStrobe <= 1'b0;
    readStrobe <= 1'b0;
    interruptEvent <= 1'b0;
    clockFailDetect <= 1'b0;
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      newSourceTick <= 1'b1;
      @(posedge clk_sys);
      newSourceTick <= 1'b0;
    end
  endtask
  task automatic restart(input logic [2:0] s, input logic [1:0] m, input logic [1:0] f);
    @(posedge clk_sys);
    rst <= 1'b1;
    srcCfg <= s;
    subCfg <= m;
    smCfg <= f;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    idle(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_reset;
    restart(3'h7, 2'h3, 2'h3);
    check(16'(activeSource), 16'h0007);
    check(16'(dozeDivisor), 16'h0001);
    check(16'(pllPostDivisor), 16'h0004);
    check(16'(pllPreDivisor), 16'h0002);
    check(16'(pllMultiplier), 16'h0032);
    check(16'(instrClockDivide2), 16'h0001);
    rd(4'h0, 16'h7700);
    rd(4'h1, 16'h3040);
    rd(4'h2, 16'h0030);
    rd(4'h3, 16'h0000);
    rd(4'h5, 16'h0000);
    unlock_wr(16'h0001);
    idle(3);
    check(16'(activeSource), 16'h0007);
    rd(4'h0, 16'h7000);
    $display("reset test done");
  endtask
  task automatic test_divisors;
    for (int i = 0; i < 8; i++) begin
      wr(4'h1, {1'b0, 3'(i), 1'b1, 3'(i), 2'b11, 1'b0, 5'(i * 4 + 3)});
      idle(1);
      check(16'(dozeDivisor), 16'h0001 << i);
      check(16'(fastRcDivisor), (i == 7) ? 16'h0100 : 16'h0001 << i);
      check(16'(pllPreDivisor), 16'(i * 4 + 5));
      check(16'(pllPostDivisor), 16'h0008);
    end
    wr(4'h1, 16'h0080);
    idle(1);
    check(16'(pllPostDivisor), 16'h0008);
    wr(4'h1, 16'hb800);
    idle(1);
    check(16'(dozeDivisor), 16'h0008);
    @(posedge clk_sys);
    interruptEvent <= 1'b1;
    idle(1);
    check(16'(dozeDivisor), 16'h0001);
    wr(4'h1, 16'h3800);
    idle(0);
    @(posedge clk_sys);
    interruptEvent <= 1'b1;
    idle(1);
    check(16'(dozeDivisor), 16'h0008);
    rd(4'h1, 16'h3800);
    wr(4'h2, 16'hffff);
    wr(4'h3, 16'hffff);
    idle(1);
    check(16'(pllMultiplier), 16'h0201);
    check(16'(fastRcTrim), 16'h003f);
    rd(4'h2, 16'h01ff);
    rd(4'h3, 16'h003f);
    $display("divisor test done");
  endtask
  task automatic test_switch;
    restart(3'h2, 2'h1, 2'h1);
    check(16'(activeSource), 16'h0002);
    check(16'(primarySubmode), 16'h0001);
    unlock_wr(16'h0201);
    idle(3);
    rd(4'h0, 16'h2200);
    @(posedge clk_sys);
    clockFailDetect <= 1'b1;
    idle(1);
    rd(4'h0, 16'h2208);
    unlock_wr(16'h0200);
    idle(1);
    rd(4'h0, 16'h2200);
    unlock_wr(16'h0043);
    idle(2);
    check(16'(pinSelectWriteAllowed), 16'h0000);
    check(16'(secondaryOscOn), 16'h0001);
    rd(4'h0, 16'h2043);
    @(posedge clk_sys);
    newSourceReady <= 1'b1;
    ticks(9);
    idle(3);
    check(16'(activeSource), 16'h0002);
    ticks(1);
    idle(3);
    check(16'(activeSource), 16'h0000);
    check(16'(primarySubmode), 16'h0001);
    rd(4'h0, 16'h0042);
    wr(4'h0, 16'h0000);
    idle(1);
    rd(4'h0, 16'h0042);
    unlock_wr(16'h0080);
    unlock_wr(16'h0481);
    idle(1);
    @(posedge clk_sys);
    pllLocked <= 1'b1;
    ticks(10);
    idle(3);
    check(16'(activeSource), 16'h0000);
    rd(4'h0, 16'h04a0);
    $display("switch test done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    test_reset;
    test_divisors;
    test_switch;
    complete_run;
  end
endmodule
`default_nettype wire
